// ==== design/pchr_pkg.sv ====
// pchr_pkg: offsets, field layout, reset values and codes for the pci config header slice
// assumes a 32-bit apb slave with one register per aligned word
package pchr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_COMMAND_WORD  = 8'h04;
  localparam logic [7:0] OFS_CLASS_REV_ID  = 8'h08;
  localparam logic [7:0] OFS_BUS_TIMING    = 8'h0C;
  localparam logic [7:0] OFS_IO_WIN_BASE   = 8'h10;
  localparam logic [7:0] OFS_MEM_WIN_BASE  = 8'h14;
  localparam int         ADDR_W            = 8;

  // command word fields
  localparam int CMD_IO_DIS_BIT  = 0;
  localparam int CMD_MEM_EN_BIT  = 1;

  // class register fields
  localparam int            CLASS_BASE_LSB = 24;
  localparam int            CLASS_SUB_LSB  = 16;
  localparam int            CLASS_REV_LSB  = 4;
  localparam int            CLASS_STEP_LSB = 0;
  localparam logic [7:0]    BASE_CLASS_NET = 8'h02;
  localparam logic [7:0]    SUBCLASS_ETH   = 8'h00;
  // arbitrary identification values, not those of any real part
  localparam logic [3:0]    REVISION_DEF   = 4'h2;
  localparam logic [3:0]    STEPPING_DEF   = 4'h5;

  // bus timing fields
  localparam int TENURE_LSB = 8;
  localparam int LINE_LSB   = 0;

  // base register layout
  localparam int         WIN_LSB        = 7;
  localparam int         WIN_W          = 25;
  localparam int         IO_FLAG_BIT    = 0;

  // reset values
  localparam logic [1:0]       COMMAND_RST  = 2'h0;
  localparam logic [7:0]       TENURE_RST   = 8'h00;
  localparam logic [7:0]       LINE_RST     = 8'h00;
  localparam logic [WIN_W-1:0] WIN_RST      = 25'h000_0000;

  // supported line sizes in double words
  localparam logic [7:0] LINE_8DW  = 8'h08;
  localparam logic [7:0] LINE_16DW = 8'h10;
  localparam logic [7:0] LINE_32DW = 8'h20;

  // cache alignment codes driven to the master engine
  typedef enum logic [1:0] {
    PCHR_ALIGN_NONE,
    PCHR_ALIGN_8DW,
    PCHR_ALIGN_16DW,
    PCHR_ALIGN_32DW
  } pchr_align_t;

endpackage

// ==== design/pchr_tenure_timer.sv ====
// pchr_tenure_timer: master latency timer and termination request
// assumes frame_drive/gnt_active are synchronous to pclk
`timescale 1ns/1ps
module pchr_tenure_timer #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // programmed tenure and bus state
  input  wire logic [CNT_W-1:0] tenure_limit,
  input  wire logic             frame_drive,
  input  wire logic             gnt_active,
  // result
  output logic                  tenure_expired,
  output logic                  tenure_stop
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_expired;
  logic             next_stop;

  // count from frame assertion, saturate at the limit
  always_comb begin
    next_count   = '0;
    next_expired = 1'b0;
    next_stop    = 1'b0;
    if (frame_drive) begin
      if (count < tenure_limit) begin
        next_count = count + CNT_W'(1);
      end else begin
        next_count = count;
      end
      next_expired = (next_count >= tenure_limit);
      // grant gone after expiry: end the tenure now
      next_stop = next_expired && !gnt_active;
    end
  end

  // counter and result flops, cleared with the bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count          <= '0;
      tenure_expired <= 1'b0;
      tenure_stop    <= 1'b0;
    end else begin
      count          <= next_count;
      tenure_expired <= next_expired;
      tenure_stop    <= next_stop;
    end
  end

endmodule

// ==== design/pchr_window_decode.sv ====
// pchr_window_decode: matches target addresses against the io and memory windows
// assumes the address strobe is one cycle wide and synchronous to pclk
`timescale 1ns/1ps
module pchr_window_decode #(
  parameter int WIN_W = 25
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // window setup
  input  wire logic [WIN_W-1:0] io_base,
  input  wire logic [WIN_W-1:0] mem_base,
  input  wire logic             io_decode_disable,
  input  wire logic             mem_decode_enable,
  // target request
  input  wire logic             tgt_valid,
  input  wire logic             tgt_is_io,
  input  wire logic [31:0]      tgt_addr,
  // result
  output logic                  tgt_hit_io,
  output logic                  tgt_hit_mem,
  output logic [31-WIN_W:0]     tgt_reg_ofs
);

  logic              next_hit_io;
  logic              next_hit_mem;
  logic [31-WIN_W:0] next_ofs;
  logic              base_match_io;
  logic              base_match_mem;

  // both windows cover the same register block; each has its own base, cycle type and enable
  always_comb begin
    base_match_io  = (tgt_addr[31:32-WIN_W] == io_base);
    base_match_mem = (tgt_addr[31:32-WIN_W] == mem_base);
    next_hit_io    = tgt_valid && tgt_is_io && base_match_io && !io_decode_disable;
    next_hit_mem   = tgt_valid && !tgt_is_io && base_match_mem && mem_decode_enable;
    next_ofs       = tgt_addr[31-WIN_W:0];
  end

  // result flops; a hit stands one cycle per strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_hit_io  <= 1'b0;
      tgt_hit_mem <= 1'b0;
      tgt_reg_ofs <= '0;
    end else begin
      tgt_hit_io  <= next_hit_io;
      tgt_hit_mem <= next_hit_mem;
      tgt_reg_ofs <= next_ofs;
    end
  end

endmodule

// ==== design/pchr_config_regs.sv ====
// pchr_config_regs: pci configuration header slice reached over apb
// assumes apb3 master on pclk, config cycles already turned into apb transfers
// assumes frame_drive and gnt_active come from the master engine on pclk
// assumes the bridge never splits a dword; there are no byte strobes
// assumes target cycles reach the decoder one address per valid strobe
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module pchr_config_regs #(
  parameter logic [3:0] REVISION = pchr_pkg::REVISION_DEF,
  parameter logic [3:0] STEPPING = pchr_pkg::STEPPING_DEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // bus master state from the dma engine
  input  wire logic        frame_drive,
  input  wire logic        gnt_active,
  // master controls
  output logic             tenure_expired,
  output logic             tenure_stop,
  output logic [1:0]       line_align,
  // target address decode
  input  wire logic        tgt_valid,
  input  wire logic        tgt_is_io,
  input  wire logic [31:0] tgt_addr,
  output logic             tgt_hit_io,
  output logic             tgt_hit_mem,
  output logic [6:0]       tgt_reg_ofs,
  // decode enables seen by the rest of the chip
  output logic             io_decode_disable,
  output logic             mem_decode_enable
);

  // base field width, shared with the window decoder
  localparam int WIN_W = pchr_pkg::WIN_W;

  // stored register state
  logic [7:0]       bus_tenure_timer;
  logic [7:0]       line_size_dw;
  logic [WIN_W-1:0] io_window_base;
  logic [WIN_W-1:0] mem_window_base;
  logic [7:0]       next_bus_tenure_timer;
  logic [7:0]       next_line_size_dw;
  logic [WIN_W-1:0] next_io_window_base;
  logic [WIN_W-1:0] next_mem_window_base;
  logic             next_io_decode_disable;
  logic             next_mem_decode_enable;

  // bus handshake state
  logic             next_pready;
  logic             next_pslverr;
  logic [31:0]      next_prdata;
  logic             access;
  logic             commit;
  logic             mapped;
  logic [31:0]      read_mux;
  logic [31:0]      class_revision_id;
  logic [1:0]       next_line_align;
  // readable images of the stored registers
  logic [31:0]      command_word;
  logic [31:0]      bus_timing_cfg;
  logic [31:0]      io_window_word;
  logic [31:0]      mem_window_word;

  // access phase gets one wait state so read data comes from a flop
  always_comb begin
    access = psel && penable;
    commit = access && pready;
  end

  // offset decode; anything off the map answers with an error
  // an error rather than silence, so a stray dword shows up at the bridge
  always_comb begin
    case (paddr)
      pchr_pkg::OFS_COMMAND_WORD,
      pchr_pkg::OFS_CLASS_REV_ID,
      pchr_pkg::OFS_BUS_TIMING,
      pchr_pkg::OFS_IO_WIN_BASE,
      pchr_pkg::OFS_MEM_WIN_BASE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // class word is fully constant
  // revision and stepping are parameters so a respin needs no logic change
  always_comb begin
    class_revision_id = '0;
    class_revision_id[pchr_pkg::CLASS_BASE_LSB +: 8] = pchr_pkg::BASE_CLASS_NET;
    class_revision_id[pchr_pkg::CLASS_SUB_LSB +: 8]  = pchr_pkg::SUBCLASS_ETH;
    class_revision_id[pchr_pkg::CLASS_REV_LSB +: 4]  = REVISION;
    class_revision_id[pchr_pkg::CLASS_STEP_LSB +: 4] = STEPPING;
  end

  // full register images; reserved bits are tied to zero in one place
  // so the read mux cannot leak a stale field into a reserved range
  always_comb begin
    command_word    = '0;
    bus_timing_cfg  = '0;
    io_window_word  = '0;
    mem_window_word = '0;
    command_word[pchr_pkg::CMD_IO_DIS_BIT]    = io_decode_disable;
    command_word[pchr_pkg::CMD_MEM_EN_BIT]    = mem_decode_enable;
    bus_timing_cfg[pchr_pkg::TENURE_LSB +: 8] = bus_tenure_timer;
    bus_timing_cfg[pchr_pkg::LINE_LSB +: 8]   = line_size_dw;
    io_window_word[31:pchr_pkg::WIN_LSB]      = io_window_base;
    io_window_word[pchr_pkg::IO_FLAG_BIT]     = 1'b1;
    mem_window_word[31:pchr_pkg::WIN_LSB]     = mem_window_base;
  end

  // read mux; holes in the map read zero
  always_comb begin
    read_mux = '0;
    case (paddr)
      pchr_pkg::OFS_COMMAND_WORD: begin
        read_mux = command_word;
      end
      pchr_pkg::OFS_CLASS_REV_ID: begin
        read_mux = class_revision_id;
      end
      pchr_pkg::OFS_BUS_TIMING: begin
        read_mux = bus_timing_cfg;
      end
      pchr_pkg::OFS_IO_WIN_BASE: begin
        read_mux = io_window_word;
      end
      pchr_pkg::OFS_MEM_WIN_BASE: begin
        read_mux = mem_window_word;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  // handshake: pready rises in the second access cycle, then drops
  // writes need psel at the answer edge, so an early drop writes nothing
  always_comb begin
    next_pready  = access && !pready;
    next_pslverr = access && !pready && !mapped;
    next_prdata  = prdata;
    if (access && !pready) begin
      next_prdata = (!pwrite && mapped) ? read_mux : 32'h0000_0000;
    end else if (!psel) begin
      next_prdata = 32'h0000_0000;
    end
  end

  // answer flops; the wait state buys a registered read path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // register writes land on the completing edge only
  // the class word has no write path; its bits are fixed
  always_comb begin
    next_io_decode_disable = io_decode_disable;
    next_mem_decode_enable = mem_decode_enable;
    next_bus_tenure_timer  = bus_tenure_timer;
    next_line_size_dw      = line_size_dw;
    next_io_window_base    = io_window_base;
    next_mem_window_base   = mem_window_base;
    if (commit && pwrite) begin
      case (paddr)
        pchr_pkg::OFS_COMMAND_WORD: begin
          next_io_decode_disable = pwdata[pchr_pkg::CMD_IO_DIS_BIT];
          next_mem_decode_enable = pwdata[pchr_pkg::CMD_MEM_EN_BIT];
        end
        pchr_pkg::OFS_BUS_TIMING: begin
          next_bus_tenure_timer = pwdata[pchr_pkg::TENURE_LSB +: 8];
          next_line_size_dw     = pwdata[pchr_pkg::LINE_LSB +: 8];
        end
        pchr_pkg::OFS_IO_WIN_BASE: begin
          next_io_window_base = pwdata[31:pchr_pkg::WIN_LSB];
        end
        pchr_pkg::OFS_MEM_WIN_BASE: begin
          next_mem_window_base = pwdata[31:pchr_pkg::WIN_LSB];
        end
        default: begin
          // class word and holes take no write
          next_io_decode_disable = io_decode_disable;
        end
      endcase
    end
  end

  // stored fields; reset leaves both windows closed to memory cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_decode_disable <= pchr_pkg::COMMAND_RST[pchr_pkg::CMD_IO_DIS_BIT];
      mem_decode_enable <= pchr_pkg::COMMAND_RST[pchr_pkg::CMD_MEM_EN_BIT];
      bus_tenure_timer  <= pchr_pkg::TENURE_RST;
      line_size_dw      <= pchr_pkg::LINE_RST;
      io_window_base    <= pchr_pkg::WIN_RST;
      mem_window_base   <= pchr_pkg::WIN_RST;
    end else begin
      io_decode_disable <= next_io_decode_disable;
      mem_decode_enable <= next_mem_decode_enable;
      bus_tenure_timer  <= next_bus_tenure_timer;
      line_size_dw      <= next_line_size_dw;
      io_window_base    <= next_io_window_base;
      mem_window_base   <= next_mem_window_base;
    end
  end

  // alignment for cache-oriented commands; odd sizes fall back to none
  // so a bad line size never makes the engine split on a wrong boundary
  always_comb begin
    case (line_size_dw)
      pchr_pkg::LINE_8DW: begin
        next_line_align = pchr_pkg::PCHR_ALIGN_8DW;
      end
      pchr_pkg::LINE_16DW: begin
        next_line_align = pchr_pkg::PCHR_ALIGN_16DW;
      end
      pchr_pkg::LINE_32DW: begin
        next_line_align = pchr_pkg::PCHR_ALIGN_32DW;
      end
      default: begin
        next_line_align = pchr_pkg::PCHR_ALIGN_NONE;
      end
    endcase
  end

  // registered so the engine sees a glitch-free alignment code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_align <= pchr_pkg::PCHR_ALIGN_NONE;
    end else begin
      line_align <= next_line_align;
    end
  end

  // master tenure timer
  // the timer only reads the stored limit; software alone changes it
  pchr_tenure_timer #(
    .CNT_W (8)
  ) u_tenure (
    .pclk           (pclk),
    .presetn        (presetn),
    .tenure_limit   (bus_tenure_timer),
    .frame_drive    (frame_drive),
    .gnt_active     (gnt_active),
    .tenure_expired (tenure_expired),
    .tenure_stop    (tenure_stop)
  );

  // io and memory window match
  // both windows share one offset field; each has its own base and enable
  pchr_window_decode #(
    .WIN_W (WIN_W)
  ) u_decode (
    .pclk              (pclk),
    .presetn           (presetn),
    .io_base           (io_window_base),
    .mem_base          (mem_window_base),
    .io_decode_disable (io_decode_disable),
    .mem_decode_enable (mem_decode_enable),
    .tgt_valid         (tgt_valid),
    .tgt_is_io         (tgt_is_io),
    .tgt_addr          (tgt_addr),
    .tgt_hit_io        (tgt_hit_io),
    .tgt_hit_mem       (tgt_hit_mem),
    .tgt_reg_ofs       (tgt_reg_ofs)
  );

endmodule

// ==== bench/pchr_config_props.sv ====
// pchr_config_props: concurrent checks on the config header slice
// assumes bound onto pchr_config_regs, one pclk domain
`timescale 1ns/1ps
module pchr_config_props (
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // master state and decode
  input wire logic        frame_drive,
  input wire logic        gnt_active,
  input wire logic        tenure_expired,
  input wire logic        tenure_stop,
  input wire logic        tgt_valid,
  input wire logic        tgt_is_io,
  input wire logic        tgt_hit_io,
  input wire logic        tgt_hit_mem,
  input wire logic        io_decode_disable,
  input wire logic        mem_decode_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read completion and mapped offset helpers
  logic rd;
  logic mapped;
  assign rd     = pready && !pwrite;
  assign mapped = paddr inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_class_fixed: assert property (rd && paddr == 8'h08 |-> prdata[31:8] == 24'h02_0000)
    else $error("class fields wrong");
  a_io_low: assert property (rd && paddr == 8'h10 |-> !pslverr && prdata[6:0] == 7'h01)
    else $error("io base low bits wrong");
  a_mem_low: assert property (rd && paddr == 8'h14 |-> !pslverr && prdata[6:0] == 7'h00)
    else $error("mem base low bits wrong");
  a_timing_rsvd: assert property (rd && paddr == 8'h0C |-> prdata[31:16] == 16'h0000)
    else $error("timing reserved bits set");
  a_cmd_update: assert property (pready && pwrite && paddr == 8'h04
    |=> {mem_decode_enable, io_decode_disable} == $past(pwdata[1:0]))
    else $error("command bits not updated");
  a_io_hit: assert property (tgt_hit_io |-> $past(tgt_valid && tgt_is_io && !io_decode_disable))
    else $error("io hit without cause");
  a_mem_hit: assert property (tgt_hit_mem |-> $past(tgt_valid && !tgt_is_io && mem_decode_enable))
    else $error("mem hit without cause");
  a_stop_cause: assert property (tenure_stop |-> tenure_expired && $past(frame_drive && !gnt_active))
    else $error("tenure stop without cause");
  // main scenarios reached
  c_class: cover property (rd && paddr == 8'h08);
  c_stop: cover property (tenure_stop);
  c_mem: cover property (tgt_hit_mem);
endmodule

// ==== bench/pchr_host_bfm.sv ====
// pchr_host_bfm: host bridge side, config dword cycles as apb transfers
// assumes one caller at a time, waits bounded by the bench timeout
`timescale 1ns/1ps
module pchr_host_bfm (
  // clock
  input wire logic   pclk,
  // apb request
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic   pready
);
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d; // released data no longer shows the old word
  endtask
endmodule

// ==== bench/tb.sv ====
// tb: self-checking bench for pchr_config_regs
// assumes pchr_host_bfm as apb master, checker bound below
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_drive, gnt_active;
  logic tgt_valid, tgt_is_io, tgt_hit_io, tgt_hit_mem, tenure_expired, tenure_stop;
  logic io_decode_disable, mem_decode_enable;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, tgt_addr, v;
  logic [1:0]  line_align;
  logic [6:0]  tgt_reg_ofs;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  int err_count, comparisons, cyc;
  logic [7:0] ofs[5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0] sz[6]  = '{8'h08, 8'h10, 8'h20, 8'h04, 8'h00, 8'h40};
  logic [1:0] al[6]  = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
  localparam logic [31:0] CLASS_V = {pchr_pkg::BASE_CLASS_NET, pchr_pkg::SUBCLASS_ETH, 8'h00,
                                     pchr_pkg::REVISION_DEF, pchr_pkg::STEPPING_DEF};
  pchr_host_bfm host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));
  pchr_config_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_drive(frame_drive), .gnt_active(gnt_active),
    .tenure_expired(tenure_expired), .tenure_stop(tenure_stop), .line_align(line_align),
    .tgt_valid(tgt_valid), .tgt_is_io(tgt_is_io), .tgt_addr(tgt_addr), .tgt_hit_io(tgt_hit_io),
    .tgt_hit_mem(tgt_hit_mem), .tgt_reg_ofs(tgt_reg_ofs), .io_decode_disable(io_decode_disable),
    .mem_decode_enable(mem_decode_enable));
  // expected read value after writing d; reset values come from d = 0
  function automatic logic [31:0] back(input logic [7:0] a, input logic [31:0] d);
    case (a)
      8'h04:   back = {30'h0, d[1:0]};
      8'h0C:   back = {16'h0, d[15:0]};
      8'h10:   back = {d[31:7], 7'h01};
      8'h14:   back = {d[31:7], 7'h00};
      default: back = CLASS_V;
    endcase
  endfunction
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    host_u.xfer(w, a, d);
  endtask
  // check timer outputs mid-cycle, then drive grant and frame at the edge
  task automatic tick(input logic e, input logic s, input logic g, input logic f);
    @(negedge pclk);
    `CHK({tenure_expired, tenure_stop}, {e, s})
    @(posedge pclk);
    gnt_active  <= g;
    frame_drive <= f;
  endtask
  task automatic probe(input logic io, input logic [31:0] a, input logic [1:0] hit);
    tgt_valid <= 1'b1;
    tgt_is_io <= io;
    tgt_addr  <= a;
    @(posedge pclk);
    tgt_valid <= 1'b0;
    tgt_addr  <= ~a;
    @(negedge pclk);
    `CHK({tgt_hit_io, tgt_hit_mem}, hit)
    if (hit != 2'b00) `CHK(tgt_reg_ofs, a[6:0])
    @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // watcher: oldest note against each completion
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() != 0) begin
      note = exp_q.pop_front();
      `CHK({pslverr, prdata}, note)
    end
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    presetn = 1'b0; frame_drive = 1'b0; gnt_active = 1'b0;
    tgt_valid = 1'b0; tgt_is_io = 1'b0; tgt_addr = 32'h0000_0000;
    void'($urandom(32'hbad7_1058));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) op(1'b0, ofs[i], 32'h0, {1'b0, back(ofs[i], 32'h0)});
    $display("test reset values done");
    repeat (4) foreach (ofs[i]) begin
      v = $urandom();
      op(1'b1, ofs[i], v, 33'h0);
      op(1'b0, ofs[i], 32'h0, {1'b0, back(ofs[i], v)});
      if (i == 0) `CHK({mem_decode_enable, io_decode_disable}, v[1:0])
    end
    op(1'b1, 8'h18, $urandom(), {1'b1, 32'h0});
    op(1'b0, 8'h00, 32'h0, {1'b1, 32'h0});
    $display("test write and read back done");
    foreach (sz[i]) begin
      op(1'b1, 8'h0C, {16'h0, 8'h02, sz[i]}, 33'h0);
      op(1'b0, 8'h0C, 32'h0, {17'h0, 8'h02, sz[i]});
      `CHK(line_align, al[i])
    end
    $display("test line sizes done");
    frame_drive <= 1'b1;
    gnt_active  <= 1'b1;
    tick(0, 0, 1, 1);
    tick(0, 0, 1, 1);
    tick(1, 0, 0, 1);
    tick(1, 0, 0, 0);
    tick(1, 1, 0, 0);
    tick(0, 0, 1, 0);
    tick(0, 0, 1, 0);
    $display("test tenure timer done");
    op(1'b1, 8'h10, 32'h0000_0100, 33'h0);
    op(1'b1, 8'h14, 32'h1234_5680, 33'h0);
    op(1'b1, 8'h04, 32'h0, 33'h0);
    probe(1'b1, {25'h2, 7'($urandom())}, 2'b10);
    probe(1'b1, 32'h0000_0205, 2'b00);
    probe(1'b0, 32'h1234_56A3, 2'b00);
    op(1'b1, 8'h04, 32'h0000_0003, 33'h0);
    probe(1'b1, 32'h0000_0111, 2'b00);
    probe(1'b0, {25'h0246_8AD, 7'($urandom())}, 2'b01);
    probe(1'b0, 32'h0000_0111, 2'b00);
    $display("test window decode done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(line_align, 2'h0)
    foreach (ofs[i]) op(1'b0, ofs[i], 32'h0, {1'b0, back(ofs[i], 32'h0)});
    $display("test reset mid run done");
    print_verdict();
  end
endmodule
bind pchr_config_regs pchr_config_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frame_drive(frame_drive), .gnt_active(gnt_active),
  .tenure_expired(tenure_expired), .tenure_stop(tenure_stop), .tgt_valid(tgt_valid),
  .tgt_is_io(tgt_is_io), .tgt_hit_io(tgt_hit_io), .tgt_hit_mem(tgt_hit_mem),
  .io_decode_disable(io_decode_disable), .mem_decode_enable(mem_decode_enable));
